// *** fpc_pkg.sv ***
// Purpose: Shared constants and types for the flash program, erase and protection controller.
// Assumes: 256 KB array, 32-bit words, 1 KB pages, 2 KB protection blocks.
// Notes:   Offsets, keys and command field positions used by the logic live here; prot_sel_i fields are decoded in fpc_flash_ctrl.
// Behaviour
// - Erase works on one 1-KB page and sets every bit of it to one.
// - Single program writes one 32-bit word and only clears bits.
// - A write buffer programs the loaded ones of 32 consecutive words in one operation.
// - Per 2-KB block, one read-enable and one program-enable bit, four 32-bit pairs.
// - Program-enable zero forbids program and erase of that block.
// - Read-enable zero allows only instruction fetches, no data reads.
// - A data read of a read-protected block answers with a bus fault.
// - Program or erase on protected block is refused and sets access flag.
// - All protection bits default to one, open access.
// - Protection bits only clear by software; commit makes it permanent.
// - Completion flag is set whenever a program or erase finishes.
// - Raw flags always visible; masked status is raw AND mask, drives interrupt.
// - Writing one to the clear port clears raw and masked flag; zero does nothing.
// - While an operation runs, flash access is blocked and fetches stall.
// - Keyed write command programs a word; write bit stays set until done.
// - Keyed erase command erases a page; erase bit stays set until done.
// - Software requests power-down and waits for the acknowledge before power loss.
// - Keyed mass-erase command erases the array; bit stays set until done.
// - Keyed buffered command writes the aligned 32-word buffer; bit held until done.
package fpc_pkg;
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 32;
   localparam int NUM_BLK    = 128;
   localparam int BLK_LSB    = 11;
   localparam int BLK_W      = 7;
   localparam int PROT_REGS  = 4;
   localparam int BUF_WORDS  = 32;
   localparam int BUF_IDX_W  = 5;
   localparam int WORD_LSB   = 2;
   localparam int KEY_LSB    = 16;
   localparam int KEY_W      = 16;
   localparam logic [15:0] WRITE_KEY = 16'ha442;
   localparam int BIT_WRITE  = 0;
   localparam int BIT_ERASE  = 1;
   localparam int BIT_MASS   = 2;
   localparam int BIT_COMMIT = 3;
   localparam int BIT_BUFWR  = 0;
   localparam int IRQ_PROG   = 0;
   localparam int IRQ_ACC    = 1;
   localparam logic [ADDR_W-1:0] WORD_MASK = 18'h00003;
   localparam logic [ADDR_W-1:0] PAGE_MASK = 18'h003ff;
   localparam logic [ADDR_W-1:0] BUF_MASK  = 18'h0007f;
   localparam logic [NUM_BLK-1:0] PROT_RESET = '1;
   typedef enum logic [1:0] {OP_PROG = 2'h0, OP_ERASE = 2'h1, OP_MASS = 2'h2} fpc_op_t;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_SCAN = 2'h3} fpc_state_t;
endpackage

// *** fpc_write_buffer.sv ***
// Purpose: 32-word write buffer with one valid bit per word.
// Assumes: Reset is the already synchronised copy.
// Notes:   A write in the same cycle as a clear keeps its valid bit.
`timescale 1ns/1ps
module fpc_write_buffer #(
   parameter int WORDS = 32,
   parameter int DW    = 32,
   parameter int IW    = 5
) (
   input  wire logic          clock_i,   // System clock.
   input  wire logic          rst_n_i,   // Synchronised reset, active low.
   input  wire logic          wr_i,      // Word write strobe.
   input  wire logic [IW-1:0] wr_idx_i,  // Word index written.
   input  wire logic [DW-1:0] wr_data_i, // Word data written.
   input  wire logic          clr_i,     // Clear all valid bits.
   input  wire logic [IW-1:0] rd_idx_i,  // Word index read.
   output logic [DW-1:0]      rd_data_o, // Word data read.
   output logic [WORDS-1:0]   valid_o    // Words written since last buffered write.
);
   logic [DW-1:0] mem [WORDS];

   always_ff @(posedge clock_i)
   begin
      if (wr_i)
      begin
         mem[wr_idx_i] <= wr_data_i;
      end
   end

   // Set wins over clear so a word loaded during completion is not lost.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         valid_o <= '0;
      end
      else
      begin
         valid_o <= (valid_o & ~{WORDS{clr_i}}) | (WORDS'(wr_i) << wr_idx_i);
      end
   end

   assign rd_data_o = mem[rd_idx_i];
endmodule // fpc_write_buffer

// *** fpc_flash_ctrl.sv ***
// Purpose: Sequences keyed program, page erase, mass erase and buffered writes; checks protection.
// Assumes: Software-side ports are on clock_i; array signals completion with arr_done_i.
// Notes:   The array programs by clearing only the bits that are zero in arr_wdata_o.
`timescale 1ns/1ps
module fpc_flash_ctrl (
   input  wire logic                        clock_i,                 // 20 MHz system clock.
   input  wire logic                        rst_n_i,                 // Power-on reset, active low.
   input  wire logic                        command_reg_wr_i,        // Command word write strobe.
   input  wire logic [31:0]                 command_reg_data_i,      // Command word.
   input  wire logic                        buffered_command_reg_wr_i,   // Buffered command strobe.
   input  wire logic [31:0]                 buffered_command_reg_data_i, // Buffered command word.
   input  wire logic [17:0]                 target_address_reg_i,    // Target byte address.
   input  wire logic [31:0]                 source_data_reg_i,       // Word to program.
   input  wire logic                        wb_wr_i,                 // Buffer word write strobe.
   input  wire logic [4:0]                  wb_idx_i,                // Buffer word index.
   input  wire logic [31:0]                 wb_data_i,               // Buffer word data.
   input  wire logic                        prot_wr_i,               // Protection word write.
   input  wire logic [2:0]                  prot_sel_i,              // Bit 2: program set; 1:0 word.
   input  wire logic [31:0]                 prot_data_i,             // Zeros clear protection bits.
   input  wire logic [127:0]                nv_read_en_i,            // Committed read enables.
   input  wire logic [127:0]                nv_prog_en_i,            // Committed program enables.
   input  wire logic [1:0]                  irq_mask_reg_i,          // Interrupt mask bits.
   input  wire logic [1:0]                  masked_status_clear_reg_i, // Write-one-to-clear.
   input  wire logic                        power_down_request_i,    // Power-down request.
   input  wire logic                        rd_req_i,                // Flash read request.
   input  wire logic                        rd_fetch_i,              // Read is an instruction fetch.
   input  wire logic [17:0]                 rd_addr_i,               // Read byte address.
   input  wire logic                        arr_done_i,              // Array operation finished.
   output logic                             write_bit_o,             // Word program running.
   output logic                             erase_bit_o,             // Page erase running.
   output logic                             whole_array_erase_bit_o, // Mass erase running.
   output logic                             buffered_write_bit_o,    // Buffered write running.
   output logic [31:0]                      wb_valid_o,              // Buffer words loaded.
   output logic [127:0]                     block_read_enable_bits_o,    // Read enables.
   output logic [127:0]                     block_program_enable_bits_o, // Program enables.
   output logic                             nv_commit_o,             // Commit protection pulse.
   output logic [1:0]                       raw_irq_status_o,        // Raw flags.
   output logic [1:0]                       masked_irq_status_o,     // Masked flags.
   output logic                             irq_o,                   // Interrupt request.
   output logic                             power_down_acknowledge_o, // Power-down granted.
   output logic                             fetch_stall_o,           // Flash access held off.
   output logic                             rd_fault_o,              // Bus fault on read.
   output logic                             arr_req_o,               // Array operation request.
   output fpc_pkg::fpc_op_t                 arr_op_o,                // Array operation kind.
   output logic [17:0]                      arr_addr_o,              // Array byte address.
   output logic [31:0]                      arr_wdata_o              // Array program data.
);
   localparam int IW = fpc_pkg::BUF_IDX_W;

   function automatic logic prot_bit(input logic [fpc_pkg::NUM_BLK-1:0] v,
                                     input logic [fpc_pkg::ADDR_W-1:0]  a);
      prot_bit = v[a[fpc_pkg::BLK_LSB +: fpc_pkg::BLK_W]];
   endfunction

   function automatic logic key_ok(input logic [31:0] w);
      key_ok = (w[fpc_pkg::KEY_LSB +: fpc_pkg::KEY_W] == fpc_pkg::WRITE_KEY);
   endfunction

   logic [1:0]                 rst_sync;
   logic                       rst_n;
   fpc_pkg::fpc_state_t        state;
   logic [IW:0]                idx;
   logic [31:0]                buf_rd_data;
   logic                       nv_loaded;
   logic                       committed;
   logic                       idle;
   logic                       cmd_ok;
   logic                       buf_ok;
   logic                       go_w;
   logic                       go_e;
   logic                       go_m;
   logic                       go_b;
   logic                       go_c;
   logic                       viol;
   logic                       launch;
   logic                       finish;
   logic                       buf_clr;
   logic [fpc_pkg::ADDR_W-1:0] buf_base;
   logic [1:0]                 next_raw;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_sync <= 2'h0;
      end
      else
      begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign idle   = (state == fpc_pkg::ST_IDLE);
   assign cmd_ok = command_reg_wr_i && key_ok(command_reg_data_i) && idle;
   assign buf_ok = buffered_command_reg_wr_i && key_ok(buffered_command_reg_data_i)
                   && idle;
   assign go_w = cmd_ok && command_reg_data_i[fpc_pkg::BIT_WRITE];
   assign go_e = cmd_ok && !go_w && command_reg_data_i[fpc_pkg::BIT_ERASE];
   assign go_m = cmd_ok && !go_w && !go_e && command_reg_data_i[fpc_pkg::BIT_MASS];
   assign go_c = cmd_ok && !go_w && !go_e && !go_m && command_reg_data_i[fpc_pkg::BIT_COMMIT];
   // The main command port wins when both are written with a valid key in one cycle.
   assign go_b = buf_ok && !cmd_ok && buffered_command_reg_data_i[fpc_pkg::BIT_BUFWR];

   // A mass erase cannot spare protected blocks, so any protected block refuses it.
   assign viol = ((go_w || go_e || go_b)
                  && !prot_bit(block_program_enable_bits_o, target_address_reg_i))
                 || (go_m && !(&block_program_enable_bits_o));
   assign launch   = (go_w || go_e || go_m || go_b) && !viol;
   assign finish   = ((state == fpc_pkg::ST_RUN) && arr_done_i && !buffered_write_bit_o)
                     || ((state == fpc_pkg::ST_SCAN) && idx[IW]);
   assign buf_clr  = (state == fpc_pkg::ST_SCAN) && idx[IW];
   assign buf_base = target_address_reg_i & ~fpc_pkg::BUF_MASK;

   fpc_write_buffer #(
      .WORDS (fpc_pkg::BUF_WORDS),
      .DW    (fpc_pkg::DATA_W),
      .IW    (IW)
   ) u_buf (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n),
      .wr_i      (wb_wr_i),
      .wr_idx_i  (wb_idx_i),
      .wr_data_i (wb_data_i),
      .clr_i     (buf_clr),
      .rd_idx_i  (idx[IW-1:0]),
      .rd_data_o (buf_rd_data),
      .valid_o   (wb_valid_o)
   );

   // Operation sequencer and array request.
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state       <= fpc_pkg::ST_IDLE;
         idx         <= '0;
         arr_req_o   <= 1'b0;
         arr_op_o    <= fpc_pkg::OP_PROG;
         arr_addr_o  <= '0;
         arr_wdata_o <= '0;
      end
      else
      begin
         unique case (state)
            fpc_pkg::ST_IDLE:
            begin
               if (launch && go_b)
               begin
                  state <= fpc_pkg::ST_SCAN;
                  idx   <= '0;
               end
               else if (launch)
               begin
                  state       <= fpc_pkg::ST_RUN;
                  arr_req_o   <= 1'b1;
                  arr_wdata_o <= source_data_reg_i;
                  if (go_w)
                  begin
                     arr_op_o   <= fpc_pkg::OP_PROG;
                     arr_addr_o <= target_address_reg_i & ~fpc_pkg::WORD_MASK;
                  end
                  else if (go_e)
                  begin
                     arr_op_o   <= fpc_pkg::OP_ERASE;
                     arr_addr_o <= target_address_reg_i & ~fpc_pkg::PAGE_MASK;
                  end
                  else
                  begin
                     arr_op_o   <= fpc_pkg::OP_MASS;
                     arr_addr_o <= '0;
                  end
               end
            end
            fpc_pkg::ST_RUN:
            begin
               if (arr_done_i)
               begin
                  arr_req_o <= 1'b0;
                  if (buffered_write_bit_o)
                  begin
                     state <= fpc_pkg::ST_SCAN;
                     idx   <= idx + 1'b1;
                  end
                  else
                  begin
                     state <= fpc_pkg::ST_IDLE;
                  end
               end
            end
            fpc_pkg::ST_SCAN:
            begin
               // Only words loaded since the last buffered write are programmed.
               if (idx[IW])
               begin
                  state <= fpc_pkg::ST_IDLE;
               end
               else if (wb_valid_o[idx[IW-1:0]])
               begin
                  state       <= fpc_pkg::ST_RUN;
                  arr_req_o   <= 1'b1;
                  arr_op_o    <= fpc_pkg::OP_PROG;
                  arr_addr_o  <= buf_base
                                 | (fpc_pkg::ADDR_W'(idx[IW-1:0]) << fpc_pkg::WORD_LSB);
                  arr_wdata_o <= buf_rd_data;
               end
               else
               begin
                  idx <= idx + 1'b1;
               end
            end
            default:
            begin
               state <= fpc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Command bits stay set from launch until the operation completes.
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_bit_o             <= 1'b0;
         erase_bit_o             <= 1'b0;
         whole_array_erase_bit_o <= 1'b0;
         buffered_write_bit_o    <= 1'b0;
      end
      else if (launch)
      begin
         write_bit_o             <= go_w;
         erase_bit_o             <= go_e;
         whole_array_erase_bit_o <= go_m;
         buffered_write_bit_o    <= go_b;
      end
      else if (finish)
      begin
         write_bit_o             <= 1'b0;
         erase_bit_o             <= 1'b0;
         whole_array_erase_bit_o <= 1'b0;
         buffered_write_bit_o    <= 1'b0;
      end
   end

   // Committed values are loaded once, on the first edge after reset release.
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         block_read_enable_bits_o    <= fpc_pkg::PROT_RESET;
         block_program_enable_bits_o <= fpc_pkg::PROT_RESET;
         nv_loaded                   <= 1'b0;
      end
      else if (!nv_loaded)
      begin
         block_read_enable_bits_o    <= nv_read_en_i;
         block_program_enable_bits_o <= nv_prog_en_i;
         nv_loaded                   <= 1'b1;
      end
      else if (prot_wr_i && prot_sel_i[2])
      begin
         block_program_enable_bits_o[{prot_sel_i[1:0], 5'h00} +: 32] <=
            block_program_enable_bits_o[{prot_sel_i[1:0], 5'h00} +: 32] & prot_data_i;
      end
      else if (prot_wr_i)
      begin
         block_read_enable_bits_o[{prot_sel_i[1:0], 5'h00} +: 32] <=
            block_read_enable_bits_o[{prot_sel_i[1:0], 5'h00} +: 32] & prot_data_i;
      end
   end

   // Protection can be committed once; a second commit is ignored.
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         committed   <= 1'b0;
         nv_commit_o <= 1'b0;
      end
      else
      begin
         nv_commit_o <= go_c && !committed;
         committed   <= committed || go_c;
      end
   end

   // Set wins over a clear in the same cycle.
   always_comb
   begin
      next_raw = raw_irq_status_o & ~masked_status_clear_reg_i;
      next_raw[fpc_pkg::IRQ_PROG] = next_raw[fpc_pkg::IRQ_PROG] | finish;
      next_raw[fpc_pkg::IRQ_ACC]  = next_raw[fpc_pkg::IRQ_ACC] | viol;
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_irq_status_o    <= 2'h0;
         masked_irq_status_o <= 2'h0;
         irq_o               <= 1'b0;
      end
      else
      begin
         raw_irq_status_o    <= next_raw;
         masked_irq_status_o <= next_raw & irq_mask_reg_i;
         irq_o               <= |(next_raw & irq_mask_reg_i);
      end
   end

   // Access path: stall while busy, fault on data reads of read-protected blocks.
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fetch_stall_o            <= 1'b0;
         rd_fault_o               <= 1'b0;
         power_down_acknowledge_o <= 1'b0;
      end
      else
      begin
         fetch_stall_o <= launch || (!idle && !finish);
         rd_fault_o    <= rd_req_i && !rd_fetch_i
                          && !prot_bit(block_read_enable_bits_o, rd_addr_i);
         // Granting only when idle keeps a running operation from being cut by power loss.
         power_down_acknowledge_o <= power_down_request_i && idle && !launch;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n);

   chk_key_guard: assert property (command_reg_wr_i && !key_ok(command_reg_data_i) && idle
      && !buffered_command_reg_wr_i |=> idle && !arr_req_o)
      else $error("unkeyed command started an operation");
   chk_busy_hold: assert property ((state == fpc_pkg::ST_RUN) && !arr_done_i
      |=> arr_req_o && $stable(arr_addr_o) && $stable(arr_op_o))
      else $error("running operation disturbed");
   chk_prot_refuse: assert property (go_w && viol
      |=> raw_irq_status_o[fpc_pkg::IRQ_ACC] && !write_bit_o && idle)
      else $error("protected program not refused");
   chk_done_flag: assert property (finish
      |=> raw_irq_status_o[fpc_pkg::IRQ_PROG] && !write_bit_o && !erase_bit_o && idle)
      else $error("completion not flagged");
   chk_mask_and: assert property (masked_irq_status_o
      == (raw_irq_status_o & $past(irq_mask_reg_i)))
      else $error("masked status differs from raw and mask");
   chk_w1c_clear: assert property (masked_status_clear_reg_i[fpc_pkg::IRQ_PROG]
      && !finish |=> !raw_irq_status_o[fpc_pkg::IRQ_PROG])
      else $error("completion flag not cleared");
   chk_fault_cause: assert property (rd_req_i && !rd_fetch_i
      && !prot_bit(block_read_enable_bits_o, rd_addr_i) |=> rd_fault_o)
      else $error("protected read did not fault");
   chk_fetch_ok: assert property (rd_req_i && rd_fetch_i |=> !rd_fault_o)
      else $error("instruction fetch faulted");
   chk_stall_busy: assert property (launch |=> fetch_stall_o
      && !idle ##0 (fetch_stall_o == !idle))
      else $error("fetch not stalled during operation");
   chk_erase_page: assert property (launch && go_e
      |=> arr_op_o == fpc_pkg::OP_ERASE && (arr_addr_o & fpc_pkg::PAGE_MASK) == '0)
      else $error("erase address not page aligned");
   chk_clear_only: assert property (nv_loaded && $past(nv_loaded)
      |-> (block_program_enable_bits_o & ~$past(block_program_enable_bits_o)) == '0)
      else $error("protection bit was set by software");

   cov_word_prog: cover property (launch && go_w ##[1:100] finish);
   cov_buf_write: cover property (launch && go_b ##[1:400] finish);
   cov_violation: cover property (viol);
   cov_read_fault: cover property (rd_fault_o);
endmodule // fpc_flash_ctrl

// *** fpc_array_model.sv ***
// Purpose: Flash array stand-in that answers each request after a fixed delay.
// Assumes: The request stays high until the cycle after done.
// Notes:   Holds no contents; only the completion timing is modelled.
`timescale 1ns/1ps
module fpc_array_model #(parameter int DELAY = 8) (
   input  wire logic clock_i,   // System clock.
   input  wire logic arr_req_i, // Operation request.
   output logic      arr_done_o // One-cycle completion pulse.
);
   int cnt = 0;
   initial arr_done_o = 1'b0;
   // The request lingers one cycle after done, so that cycle is not counted.
   always @(posedge clock_i)
   begin
      if (arr_done_o)
      begin
         arr_done_o <= 1'b0;
         cnt        <= 0;
      end
      else if (arr_req_i && cnt == DELAY - 1) arr_done_o <= 1'b1;
      else cnt <= arr_req_i ? cnt + 1 : 0;
   end
endmodule // fpc_array_model

// *** flash_program_erase_protect_ctrl_tb_top.sv ***
// Purpose: Directed checks of the flash sequencer through its command and status ports.
// Assumes: Array answers after a fixed delay; committed protection reads all ones.
// Notes:   Mass erase is only tried against a protected array, so it must be refused.
`timescale 1ns/1ps
module flash_program_erase_protect_ctrl_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, cw = 1'b0, pw = 1'b0, rd = 1'b0, fe = 1'b0, pdr = 1'b0, dn;
   logic bcw = 1'b0, wbw = 1'b0, mb, bw, cm;
   logic [31:0] cmd = 32'h0, pd = 32'h0, dat = 32'h0f0f00ff, wd, wv;
   logic [2:0] ps = 3'h0;
   logic [1:0] mk = 2'h0, cl = 2'h0, raw, msk;
   logic [17:0] ad = 18'h0, aa;
   logic [127:0] nv = '1, re, pe;
   logic wp, me, st, fl, rq, irq, ack;
   fpc_pkg::fpc_op_t op;
   int bad_count = 0, n_tests = 0, cyc = 0;
   fpc_array_model arr (.clock_i(clk), .arr_req_i(rq), .arr_done_o(dn));
   fpc_flash_ctrl dut (.clock_i(clk), .rst_n_i(rst_n), .command_reg_wr_i(cw),
      .command_reg_data_i(cmd), .buffered_command_reg_wr_i(bcw),
      .buffered_command_reg_data_i(cmd), .target_address_reg_i(ad), .source_data_reg_i(dat),
      .wb_wr_i(wbw), .wb_idx_i(ad[6:2]), .wb_data_i(dat), .prot_wr_i(pw), .prot_sel_i(ps),
      .prot_data_i(pd), .nv_read_en_i(nv), .nv_prog_en_i(nv), .irq_mask_reg_i(mk),
      .masked_status_clear_reg_i(cl), .power_down_request_i(pdr), .rd_req_i(rd),
      .rd_fetch_i(fe), .rd_addr_i(ad), .arr_done_i(dn), .write_bit_o(wp), .erase_bit_o(me),
      .whole_array_erase_bit_o(mb), .buffered_write_bit_o(bw), .wb_valid_o(wv),
      .block_read_enable_bits_o(re), .block_program_enable_bits_o(pe), .nv_commit_o(cm),
      .raw_irq_status_o(raw), .masked_irq_status_o(msk), .irq_o(irq),
      .power_down_acknowledge_o(ack), .fetch_stall_o(st), .rd_fault_o(fl), .arr_req_o(rq),
      .arr_op_o(op), .arr_addr_o(aa), .arr_wdata_o(wd));
   initial forever #25 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic issue(input logic [31:0] c);
      @(posedge clk) begin cmd <= c; cw <= 1'b1; end
      @(posedge clk) cw <= 1'b0;
      #1;
   endtask
   // Bounded wait so a stuck operation bit cannot hang the run.
   task automatic finish_op();
      for (int i = 0; i < 100 && (wp | me | mb | bw); i++) @(posedge clk);
      step(1);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         bad_count++;
         close_out();
      end
   end
   initial
   begin
      step(5);
      rst_n <= 1'b1;
      step(6);
      chk({31'h0, &{re, pe}}, 32'h1);
      ad <= 18'h00804;
      issue(32'ha4420001);
      chk({26'h0, wp, me, st, rq, op}, 32'h2c);
      chk({14'h0, aa}, 32'h804);
      chk(wd, 32'h0f0f00ff);
      finish_op();
      chk({28'h0, wp, st, raw}, 32'h1);
      $display("program test done");
      issue(32'ha4430002);
      chk({29'h0, wp, me, rq}, 32'h0);
      ad <= 18'h00c00;
      issue(32'ha4420002);
      chk({28'h0, me, rq, op}, 32'hd);
      issue(32'ha4420001);
      chk({30'h0, wp, me}, 32'h1);
      finish_op();
      mk <= 2'h1;
      step(2);
      chk({29'h0, irq, msk}, 32'h5);
      @(posedge clk) cl <= 2'h1;
      @(posedge clk) cl <= 2'h0;
      step(1);
      chk({27'h0, irq, msk, raw}, 32'h0);
      $display("erase and interrupt test done");
      @(posedge clk) begin ps <= 3'h4; pd <= 32'hfffffffd; pw <= 1'b1; mk <= 2'h2; end
      @(posedge clk) pw <= 1'b0;
      ad <= 18'h00808;
      issue(32'ha4420001);
      step(1);
      chk({26'h0, pe[1], wp, rq, raw, irq}, 32'h5);
      @(posedge clk) begin ps <= 3'h0; pd <= 32'hfffffffe; pw <= 1'b1; ad <= 18'h0; end
      @(posedge clk) begin pw <= 1'b0; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1;
      chk({31'h0, fl}, 32'h1);
      @(posedge clk) begin rd <= 1'b1; fe <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1;
      chk({31'h0, fl}, 32'h0);
      pdr <= 1'b1;
      step(3);
      chk({31'h0, ack}, 32'h1);
      $display("protection and power test done");
      @(posedge clk) begin cl <= 2'h2; pdr <= 1'b0; end
      @(posedge clk) cl <= 2'h0;
      issue(32'ha4420004);
      chk({28'h0, mb, rq, raw}, 32'h2);
      issue(32'ha4420008);
      chk({31'h0, cm}, 32'h1);
      @(posedge clk) begin ad <= 18'h0; dat <= 32'h12345678; wbw <= 1'b1; end
      @(posedge clk) begin ad <= 18'h0000c; dat <= 32'h0000ffff; end
      @(posedge clk) begin ad <= 18'h0; wbw <= 1'b0; cmd <= 32'ha4420001; bcw <= 1'b1; end
      @(posedge clk) bcw <= 1'b0;
      step(1);
      chk({wv[3:0], 26'h0, bw, rq}, 32'h90000003);
      chk({14'h0, aa}, 32'h0);
      chk(wd, 32'h12345678);
      finish_op();
      chk({wv[3:0], 25'h0, bw, rq, raw[0]}, 32'h1);
      $display("mass erase, commit and buffered write test done");
      close_out();
   end
endmodule // flash_program_erase_protect_ctrl_tb_top
